// [lps_map.vh]
// lps_map.vh: register offsets, field positions and reset values of the
// serializer; definitions only, included by lps_top
`ifndef LPS_MAP_VH
`define LPS_MAP_VH

// byte offsets on the register bus
`define LPS_OFS_CTRL 4'h0
`define LPS_OFS_STATUS 4'h4
`define LPS_OFS_WORD 4'h8
`define LPS_OFS_COUNT 4'hC

// control register fields
`define LPS_CTRL_SW_EN 0
`define LPS_CTRL_CNT_CLR 1
`define LPS_CTRL_RST_VAL 1'b1

// status register fields
`define LPS_STAT_ENABLED 0
`define LPS_STAT_LOCKED 1
`define LPS_STAT_CAS_EN 2
`define LPS_STAT_LINK_EN 3
`define LPS_STAT_ACTIVE 4

// widths and reset values
`define LPS_PAR_W 10
`define LPS_CNT_W 16
`define LPS_WAIT_RST_VAL 1'b1

`endif

// [lps_sync.v]
// lps_sync.v: two-flop synchroniser for a group of pin levels
// assumes inputs come from outside the CLK_I domain
`timescale 1ns/1ps
`default_nettype none
module lps_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_ff;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// [lps_shift.v]
// lps_shift.v: parallel-load shift register, lowest bit out first, with
// a serial fill bit entering at the top
// assumes adv is a one-cycle strobe on clk_i; load acts only together with adv
`timescale 1ns/1ps
`default_nettype none
module lps_shift #(
  parameter W = 10
) (
  input wire clk_i,
  input wire clr_i,
  input wire adv_i,
  input wire load_i,
  input wire [W-1:0] load_data_i,
  input wire fill_i,
  output reg [W-1:0] q_o
);
  always @(posedge clk_i)
  begin
    if (clr_i)
      q_o <= {W{1'b0}};
    else if (adv_i && load_i)
      q_o <= load_data_i;
    else if (adv_i)
      q_o <= {fill_i, q_o[W-1:1]};
  end
endmodule
`default_nettype wire

// [lps_top.v]
// lps_top.v: cascadable parallel-in serial-out serializer with link clock
// output and an avalon-mm register slave
// assumes bit and word clocks are far slower than CLK_I so that their
// edges are found after two-flop synchronisation
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lps_map.vh"
module lps_top #(
  parameter PAR_W = `LPS_PAR_W,
  parameter CNT_W = `LPS_CNT_W
) (
  input wire CLK_I,
  input wire RST_I,
  input wire [PAR_W-1:0] PAR_DATA_IN_I,
  input wire BIT_CLOCK_IN_I,
  input wire WORD_CLOCK_REF_IN_I,
  input wire CASCADE_IN_I,
  input wire CASCADE_RX_ENABLE_I,
  input wire LINK_CLOCK_OUT_ENABLE_I,
  input wire LOCK_VALID_IN_I,
  input wire ENABLE_I,
  output reg SERIAL_DATA_OUT_O,
  output reg SERIAL_DATA_OUT_OE_O,
  output reg LINK_CLOCK_OUT_O,
  output reg LINK_CLOCK_OUT_OE_O,
  input wire [3:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O
);
  localparam BUS_IDLE = 1'b0;
  localparam BUS_ANSWER = 1'b1;

  wire [PAR_W-1:0] data_s;
  wire bclk_s;
  wire wref_s;
  wire casc_s;
  wire en_s;
  wire lock_s;
  wire cre_s;
  wire lcoe_s;
  wire bclk_rise;
  wire wref_rise;
  wire enabled;
  wire hold_rst;
  wire fill_bit;
  wire capture;
  wire [PAR_W-1:0] sh_q;
  wire bus_req;
  wire bus_acc;

  reg bclk_d_ff;
  reg wref_d_ff;
  reg pend_ff;
  reg load_pend_ff;
  reg [PAR_W-1:0] latch_ff;
  reg sw_en_ff;
  reg [CNT_W-1:0] cnt_ff;
  reg [31:0] nxt_rdata;
  reg bus_st_ff;
  reg nxt_bus_st;

  // bit clock, word clock and cascade pins
  lps_sync #(
    .W(3)
  ) u_sync_clk (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i({CASCADE_IN_I, WORD_CLOCK_REF_IN_I, BIT_CLOCK_IN_I}),
    .q_o({casc_s, wref_s, bclk_s})
  );

  // control pins
  lps_sync #(
    .W(4)
  ) u_sync_ctl (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i({LINK_CLOCK_OUT_ENABLE_I, CASCADE_RX_ENABLE_I, LOCK_VALID_IN_I,
          ENABLE_I}),
    .q_o({lcoe_s, cre_s, lock_s, en_s})
  );

  // parallel data pins
  lps_sync #(
    .W(PAR_W)
  ) u_sync_dat (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(PAR_DATA_IN_I),
    .q_o(data_s)
  );

  // edge finders on the sampled clocks
  assign bclk_rise = bclk_s & ~bclk_d_ff;
  assign wref_rise = wref_s & ~wref_d_ff;

  // device enable and the combined internal reset
  assign enabled = en_s & sw_en_ff;
  assign hold_rst = RST_I | ~enabled | ~lock_s;

  // cascade receiver gated by its own enable
  assign fill_bit = casc_s & cre_s;

  // word capture on first bit clock rise after a word clock rise
  assign capture = bclk_rise & (pend_ff | wref_rise);

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      bclk_d_ff <= 1'b0;
      wref_d_ff <= 1'b0;
    end
    else
    begin
      bclk_d_ff <= bclk_s;
      wref_d_ff <= wref_s;
    end
  end

  // pending word edge: a capture in the same cycle wins over a new edge and clears it
  always @(posedge CLK_I)
  begin
    if (hold_rst)
      pend_ff <= 1'b0;
    else if (wref_rise && !bclk_rise)
      pend_ff <= 1'b1;
    else if (capture)
      pend_ff <= 1'b0;
  end

  // capture into the input latch, load the shifter one edge later
  always @(posedge CLK_I)
  begin
    if (hold_rst)
    begin
      latch_ff <= {PAR_W{1'b0}};
      load_pend_ff <= 1'b0;
    end
    else if (capture)
    begin
      latch_ff <= data_s;
      load_pend_ff <= 1'b1;
    end
    else if (bclk_rise)
      load_pend_ff <= 1'b0;
  end

  // shifter with cascade fill; a reload cuts off the previous word
  lps_shift #(
    .W(PAR_W)
  ) u_shift (
    .clk_i(CLK_I),
    .clr_i(hold_rst),
    .adv_i(bclk_rise),
    .load_i(load_pend_ff),
    .load_data_i(latch_ff),
    .fill_i(fill_bit),
    .q_o(sh_q)
  );

  // serial data: lowest shifter bit registered at each bit clock rise,
  // so bit 0 leaves on the third rise after the word edge
  always @(posedge CLK_I)
  begin
    if (hold_rst)
      SERIAL_DATA_OUT_O <= 1'b0;
    else if (bclk_rise)
      SERIAL_DATA_OUT_O <= sh_q[0];
  end

  // link clock: high from capture edge, low at first rise with ref low
  always @(posedge CLK_I)
  begin
    if (hold_rst)
      LINK_CLOCK_OUT_O <= 1'b0;
    else if (capture)
      LINK_CLOCK_OUT_O <= 1'b1;
    else if (bclk_rise && !wref_s)
      LINK_CLOCK_OUT_O <= 1'b0;
  end

  // output drivers
  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      SERIAL_DATA_OUT_OE_O <= 1'b0;
      LINK_CLOCK_OUT_OE_O <= 1'b0;
    end
    else
    begin
      SERIAL_DATA_OUT_OE_O <= enabled;
      LINK_CLOCK_OUT_OE_O <= enabled & lcoe_s;
    end
  end

  // bus slave: one wait cycle, then the request is accepted
  assign bus_req = AVS_READ_I | AVS_WRITE_I;
  assign bus_acc = bus_req & ~AVS_WAITREQUEST_O;

  // answer state follows every request seen while idle
  always @*
  begin
    nxt_bus_st = BUS_IDLE;
    case (bus_st_ff)
      BUS_IDLE:
      begin
        if (bus_req)
          nxt_bus_st = BUS_ANSWER;
      end
      BUS_ANSWER:
        nxt_bus_st = BUS_IDLE;
      default:
        nxt_bus_st = BUS_IDLE;
    endcase
  end

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      bus_st_ff <= BUS_IDLE;
      AVS_WAITREQUEST_O <= `LPS_WAIT_RST_VAL;
    end
    else
    begin
      bus_st_ff <= nxt_bus_st;
      AVS_WAITREQUEST_O <= (nxt_bus_st == BUS_IDLE);
    end
  end

  // control register
  always @(posedge CLK_I)
  begin
    if (RST_I)
      sw_en_ff <= `LPS_CTRL_RST_VAL;
    else if (bus_acc && AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
             AVS_ADDRESS_I == `LPS_OFS_CTRL)
      sw_en_ff <= AVS_WRITEDATA_I[`LPS_CTRL_SW_EN];
  end

  // captured word counter, cleared by software
  always @(posedge CLK_I)
  begin
    if (RST_I)
      cnt_ff <= {CNT_W{1'b0}};
    else if (capture && !hold_rst)
      cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    else if (bus_acc && AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
             AVS_ADDRESS_I == `LPS_OFS_CTRL &&
             AVS_WRITEDATA_I[`LPS_CTRL_CNT_CLR])
      cnt_ff <= {CNT_W{1'b0}};
  end

  // read data set up while waitrequest is high
  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    case (AVS_ADDRESS_I)
      `LPS_OFS_CTRL:
        nxt_rdata[`LPS_CTRL_SW_EN] = sw_en_ff;
      `LPS_OFS_STATUS:
      begin
        nxt_rdata[`LPS_STAT_ENABLED] = enabled;
        nxt_rdata[`LPS_STAT_LOCKED] = lock_s;
        nxt_rdata[`LPS_STAT_CAS_EN] = cre_s;
        nxt_rdata[`LPS_STAT_LINK_EN] = lcoe_s;
        nxt_rdata[`LPS_STAT_ACTIVE] = ~hold_rst;
      end
      `LPS_OFS_WORD:
        nxt_rdata[PAR_W-1:0] = latch_ff;
      `LPS_OFS_COUNT:
        nxt_rdata[CNT_W-1:0] = cnt_ff;
      default:
        nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK_I)
  begin
    if (RST_I)
      AVS_READDATA_O <= 32'h0000_0000;
    else if (AVS_READ_I && AVS_WAITREQUEST_O)
      AVS_READDATA_O <= nxt_rdata;
  end
endmodule
`default_nettype wire

// [lps_chk_sva.sv]
// lps_chk_sva.sv: port assertions for lps_top
// assumes bit clock far slower than CLK_I
`timescale 1ns/1ps
`default_nettype none
module lps_chk (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic ENABLE_I,
  input wire logic LOCK_VALID_IN_I,
  input wire logic LINK_CLOCK_OUT_ENABLE_I,
  input wire logic BIT_CLOCK_IN_I,
  input wire logic WORD_CLOCK_REF_IN_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic SERIAL_DATA_OUT_O,
  input wire logic SERIAL_DATA_OUT_OE_O,
  input wire logic LINK_CLOCK_OUT_O,
  input wire logic LINK_CLOCK_OUT_OE_O
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  a_dis_hiz: assert property (
    !ENABLE_I [*5] |-> !SERIAL_DATA_OUT_OE_O && !LINK_CLOCK_OUT_OE_O)
    else $error("driven while disabled");
  a_first_low: assert property (
    $rose(SERIAL_DATA_OUT_OE_O) |-> !SERIAL_DATA_OUT_O && !LINK_CLOCK_OUT_O)
    else $error("not low on enable");
  a_link_off: assert property (
    !LINK_CLOCK_OUT_ENABLE_I [*5] |-> !LINK_CLOCK_OUT_OE_O)
    else $error("link clock driven");
  a_lock_low: assert property (
    !LOCK_VALID_IN_I [*5] |-> !SERIAL_DATA_OUT_O && !LINK_CLOCK_OUT_O)
    else $error("output high while unlocked");
  a_link_rise: assert property (
    $rose(LINK_CLOCK_OUT_O) |-> WORD_CLOCK_REF_IN_I &&
    $past(BIT_CLOCK_IN_I, 3) && !$past(BIT_CLOCK_IN_I, 4))
    else $error("link clock rise misplaced");
  a_bit_hold: assert property (
    $changed(SERIAL_DATA_OUT_O) && LOCK_VALID_IN_I && ENABLE_I
    |=> $stable(SERIAL_DATA_OUT_O) [*3])
    else $error("serial bit too short");
  a_wait_one: assert property (
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");
  a_req_ans: assert property (
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("bus answer late");
endmodule
bind lps_top lps_chk u_lps_chk (.CLK_I(CLK_I), .RST_I(RST_I),
  .ENABLE_I(ENABLE_I), .LOCK_VALID_IN_I(LOCK_VALID_IN_I),
  .LINK_CLOCK_OUT_ENABLE_I(LINK_CLOCK_OUT_ENABLE_I),
  .BIT_CLOCK_IN_I(BIT_CLOCK_IN_I), .WORD_CLOCK_REF_IN_I(WORD_CLOCK_REF_IN_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .SERIAL_DATA_OUT_O(SERIAL_DATA_OUT_O),
  .SERIAL_DATA_OUT_OE_O(SERIAL_DATA_OUT_OE_O),
  .LINK_CLOCK_OUT_O(LINK_CLOCK_OUT_O),
  .LINK_CLOCK_OUT_OE_O(LINK_CLOCK_OUT_OE_O));
`default_nettype wire

// [lps_far.sv]
// lps_far.sv: clock multiplier and upstream serializer model
// assumes the bench sets pat and calls run
`timescale 1ns/1ps
`default_nettype none
module lps_far (
  input wire logic clk_i,
  output logic bclk_o,
  output logic ref_o,
  output logic lock_o,
  output logic casc_o,
  output int nrise_o
);
  logic [39:0] pat;
  initial
  begin
    bclk_o = 0;
    ref_o = 0;
    lock_o = 0;
    casc_o = 0;
    nrise_o = 0;
    pat = 0;
  end
  // one 80 ns bit period; every change just after a clk_i edge
  task pulse;
    repeat (5) @(posedge clk_i);
    bclk_o <= 1;
    nrise_o <= nrise_o + 1;
    repeat (5) @(posedge clk_i);
    bclk_o <= 0;
  endtask
  task run(input int m, input int w, input logic lk);
    int i;
    repeat (2) pulse();
    lock_o <= lk;
    repeat (2) pulse();
    nrise_o <= 0;
    for (i = 0; i < w * m + 2; i++)
    begin
      ref_o <= i < w * m && i % m < m / 2;
      casc_o <= pat[i % m];
      pulse();
    end
    casc_o <= ~casc_o;
  endtask
endmodule
`default_nettype wire

// [test_lps_top.sv]
// test_lps_top.sv: self-checking bench for lps_top
// assumes lps_far drives clocks, lock and cascade
`timescale 1ns/1ps
`default_nettype none
module test_lps_top;
  logic clk, rst, en, ce, le, rd, wr, e;
  logic [9:0] par;
  logic [3:0] adr;
  logic [31:0] wd, rdat;
  logic [15:0] rnd = 16'h004d;
  wire bclk, wref, lock, casc, sdo, sdo_oe, lnk, lnk_oe, wt;
  wire [31:0] rdo;
  int nrise, n_errors = 0, compares = 0;
  logic q[$];
  lps_top u_lps_top (.CLK_I(clk), .RST_I(rst), .PAR_DATA_IN_I(par),
    .BIT_CLOCK_IN_I(bclk), .WORD_CLOCK_REF_IN_I(wref), .CASCADE_IN_I(casc),
    .CASCADE_RX_ENABLE_I(ce), .LINK_CLOCK_OUT_ENABLE_I(le),
    .LOCK_VALID_IN_I(lock), .ENABLE_I(en), .SERIAL_DATA_OUT_O(sdo),
    .SERIAL_DATA_OUT_OE_O(sdo_oe), .LINK_CLOCK_OUT_O(lnk),
    .LINK_CLOCK_OUT_OE_O(lnk_oe), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdo), .AVS_WAITREQUEST_O(wt));
  lps_far u_lps_far (.clk_i(clk), .bclk_o(bclk), .ref_o(wref), .lock_o(lock),
    .casc_o(casc), .nrise_o(nrise));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task finish_test;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    for (i = 0; i < 20 && wt !== 1'b0; i++)
      @(posedge clk);
    if (i == 20)
    begin
      n_errors++;
      finish_test();
    end
    rdat = rdo;
    rd <= 0;
    wr <= 0;
  endtask
  task burst(input int m, input int w, input logic lk, input logic c);
    int i, j;
    @(posedge clk);
    ce <= c;
    rnd = lfsr(rnd);
    u_lps_far.pat = {rnd, rnd, rnd[7:0]};
    fork
      u_lps_far.run(m, w, lk);
      for (i = 0; i < w; i++)
      begin
        @(posedge wref);
        @(posedge clk);
        rnd = lfsr(rnd);
        par <= rnd[9:0];
        for (j = 0; j < m; j++)
          q.push_back(!lk ? 0 : j < 10 ? rnd[j] : c & u_lps_far.pat[j - 8]);
      end
    join
    $display("burst m=%0d done", m);
  endtask
  always @(negedge bclk)
    if (nrise >= 3 && q.size() > 0)
    begin
      e = q.pop_front();
      chk(sdo, e);
    end
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #400000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    {rst, en, ce, le, rd, wr, adr, wd, par} = {4'hf, 48'h0};
    repeat (12) @(posedge clk);
    rst <= 0;
    bus(0, 4'h0, 0);
    chk(rdat[0], 1);
    burst(10, 3, 1, 0);
    bus(0, 4'h8, 0);
    chk(rdat[9:0], par);
    burst(4, 3, 1, 1);
    burst(14, 2, 1, 1);
    burst(14, 1, 1, 0);
    burst(10, 1, 0, 0);
    bus(0, 4'h4, 0);
    chk(rdat[3:0], 4'b1001);
    le <= 0;
    repeat (6) @(posedge clk);
    chk({lnk_oe, sdo_oe}, 1);
    le <= 1;
    en <= 0;
    repeat (6) @(posedge clk);
    chk({sdo_oe, lnk_oe}, 0);
    en <= 1;
    repeat (6) @(posedge clk);
    chk({sdo_oe, sdo, lnk}, 3'b100);
    bus(1, 4'h0, 0);
    repeat (6) @(posedge clk);
    chk(sdo_oe, 0);
    bus(1, 4'h0, 3);
    bus(0, 4'h2, 0);
    chk(rdat, 0);
    burst(10, 2, 1, 0);
    bus(0, 4'hc, 0);
    chk(rdat[15:0], 16'h0002);
    finish_test();
  end
endmodule
`default_nettype wire
